// [rtl/nv_config_pkg.sv]
/*
  Constants for the power-on configuration loader of the serial flash: field positions of the stored
  configuration word, its delivery value, instruction codes and power-on timing.
  Assumes a 20 MHz system clock that oversamples the serial link.
*/
package nv_config_pkg;
  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int WORD_W = 16;
  localparam int DUMMY_HI = 15;
  localparam int DUMMY_LO = 12;
  localparam int EXEC_HI = 11;
  localparam int EXEC_LO = 9;
  localparam int DRV_HI = 8;
  localparam int DRV_LO = 6;
  localparam int FAST_POR_BIT = 5;
  localparam int HOLD_EN_BIT = 4;
  localparam int QUAD_N_BIT = 3;
  localparam int DUAL_N_BIT = 2;
  localparam logic [15:0] WORD_DELIVERY = 16'hffff;
  localparam logic [1:0] RESERVED_ONES = 2'h3;
  localparam logic [3:0] DUMMY_DEFAULT = 4'hf;
  localparam logic [2:0] EXEC_OFF = 3'h7;
  localparam logic [2:0] DRV_30_OHM = 3'h7;
  localparam logic [7:0] CMD_READ_WORD = 8'hb5;
  localparam logic [7:0] CMD_WRITE_WORD = 8'hb1;
  localparam logic [7:0] CMD_WRITE_LATCH = 8'h06;
  localparam logic [7:0] CMD_READ_STATUS = 8'h05;
  localparam logic [7:0] CMD_READ_FLAGS = 8'h70;
  localparam logic [7:0] CMD_FAST_READ = 8'h0b;
  localparam logic [7:0] CMD_READ = 8'h03;
  localparam int FAST_POR_US = 100;
  localparam int FULL_POR_US = 700;
  localparam int SECOND_PHASE_US = 500;
  // The margin covers the power pin synchroniser and the load cycle, so reads open inside the limit.
  localparam int FAST_POR_CYC = FAST_POR_US * (CLK_HZ / 1_000_000) - 8;
  localparam int FULL_POR_CYC = FULL_POR_US * (CLK_HZ / 1_000_000);
  localparam int SECOND_PHASE_CYC = SECOND_PHASE_US * (CLK_HZ / 1_000_000);
  localparam int TIMER_W = 16;
  typedef enum logic [1:0] {proto_extended, proto_dual, proto_quad} protocol_e;
endpackage : nv_config_pkg

// [rtl/pin_sync.sv]
/*
  Two-stage synchroniser for one pin level.
  Assumes the pin is asynchronous to sys_clk.
*/
`timescale 1ns/1ps
module pin_sync #(
  parameter logic IDLE = 1'b0
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic pin,
  output logic level
);
  logic stage1;
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      stage1 <= IDLE;
      level <= IDLE;
    end
    else
    begin
      stage1 <= pin;
      level <= stage1;
    end
  end
endmodule : pin_sync

// [rtl/por_timer.sv]
/*
  Countdown timer: load a cycle count, done rises when it has run out.
  Assumes the count fits the timer width.
*/
`timescale 1ns/1ps
module por_timer (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic load,
  input wire logic [nv_config_pkg::TIMER_W-1:0] count,
  output logic done
);
  import nv_config_pkg::*;
  logic [TIMER_W-1:0] remain;
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      remain <= '0;
    else if (load)
      remain <= count;
    else if (remain != '0)
      remain <= remain - 1'b1;
  end
  assign done = (remain == '0) && !load;
endmodule : por_timer

// [rtl/nv_config_loader.sv]
/*
  Power-on configuration loader of a serial flash: holds the stored configuration word, copies it
  into the working configuration at power-on, runs the (fast) power-on sequence and serves the
  read and write instructions for the word over a single-line serial link.
  Assumes a host that drives serial clock and chip select and keeps its own dummy-count choice.
*/
`timescale 1ns/1ps
module nv_config_loader (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic power_on,
  input wire logic serial_clk,
  input wire logic chip_select_n,
  input wire logic serial_in,
  output logic serial_out,
  output logic serial_out_en,
  input wire logic fourth_io_line,
  output logic [3:0] dummy_clocks,
  output logic [2:0] direct_execution_mode,
  output logic [2:0] driver_strength,
  output nv_config_pkg::protocol_e start_protocol,
  output logic hold_function_en,
  output logic hold_active,
  output logic ready,
  output logic reads_only,
  output logic polls_only
);
  import nv_config_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and serial clock edge detection.

  logic clk_s;
  logic cs_n_s;
  logic din_s;
  logic hold_s;
  logic power_on_s;
  logic clk_d;

  // Each synchroniser resets to the idle level of its pin, so no false select or hold follows reset.
  pin_sync #(
    .IDLE(1'b0)
  ) sync_clk (
    .sys_clk(sys_clk),
    .rst(rst),
    .pin(serial_clk),
    .level(clk_s)
  );
  pin_sync #(
    .IDLE(1'b1)
  ) sync_cs (
    .sys_clk(sys_clk),
    .rst(rst),
    .pin(chip_select_n),
    .level(cs_n_s)
  );
  pin_sync #(
    .IDLE(1'b0)
  ) sync_din (
    .sys_clk(sys_clk),
    .rst(rst),
    .pin(serial_in),
    .level(din_s)
  );
  pin_sync #(
    .IDLE(1'b1)
  ) sync_hold (
    .sys_clk(sys_clk),
    .rst(rst),
    .pin(fourth_io_line),
    .level(hold_s)
  );
  pin_sync #(
    .IDLE(1'b0)
  ) sync_power (
    .sys_clk(sys_clk),
    .rst(rst),
    .pin(power_on),
    .level(power_on_s)
  );

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      clk_d <= 1'b0;
    else
      clk_d <= clk_s;
  end

  wire rise = clk_s && !clk_d && !cs_n_s;
  wire fall = !clk_s && clk_d && !cs_n_s;

  ////////////////////////////////////////////////////////////////////////////
  // Stored word, working copy and power-on sequence.

  typedef enum logic [2:0] {st_off, st_load, st_boot_fast, st_boot_full, st_reads_only, st_second_phase,
                            st_ready} por_e;
  por_e por_state;
  por_e next_por_state;
  logic [15:0] stored_word;
  logic [15:0] working;
  logic [TIMER_W-1:0] timer_count;
  logic timer_load;
  logic timer_done;
  logic power_on_d;
  logic latch_cmd_seen;
  logic write_word_done;
  logic [15:0] write_shift;

  por_timer timer (
    .sys_clk(sys_clk),
    .rst(rst),
    .load(timer_load),
    .count(timer_count),
    .done(timer_done)
  );

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      power_on_d <= 1'b0;
    else
      power_on_d <= power_on_s;
  end

  wire power_rise = power_on_s && !power_on_d;
  wire fast_por = !working[FAST_POR_BIT];

  always_comb
  begin
    next_por_state = por_state;
    timer_load = 1'b0;
    timer_count = '0;
    case (por_state)
      st_off:
        if (power_rise)
          next_por_state = st_load;
      st_load:
      begin
        timer_load = 1'b1;
        if (!stored_word[FAST_POR_BIT])
        begin
          timer_count = TIMER_W'(FAST_POR_CYC);
          next_por_state = st_boot_fast;
        end
        else
        begin
          timer_count = TIMER_W'(FULL_POR_CYC);
          next_por_state = st_boot_full;
        end
      end
      st_boot_fast:
        if (timer_done)
          next_por_state = st_reads_only;
      st_boot_full:
        if (timer_done)
          next_por_state = st_ready;
      st_reads_only:
        if (latch_cmd_seen)
        begin
          timer_load = 1'b1;
          timer_count = TIMER_W'(SECOND_PHASE_CYC);
          next_por_state = st_second_phase;
        end
      st_second_phase:
        if (timer_done)
          next_por_state = st_ready;
      st_ready:
        next_por_state = st_ready;
      default:
        next_por_state = st_off;
    endcase
    if (!power_on_s)
      next_por_state = st_off;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      por_state <= st_off;
    else
      por_state <= next_por_state;
  end

  // Copy every field once per power-on, so later writes only act at the next one.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      working <= WORD_DELIVERY;
    else if (por_state == st_load)
      working <= stored_word;
  end

  // Stored word survives power cycles; rst stands for factory delivery.
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      stored_word <= WORD_DELIVERY;
    else if (write_word_done)
      stored_word <= {write_shift[14:1], RESERVED_ONES};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Working configuration outputs.

  wire [3:0] dummy_field = working[DUMMY_HI:DUMMY_LO];
  assign dummy_clocks = (dummy_field == 4'h0) ? DUMMY_DEFAULT : dummy_field;
  assign direct_execution_mode = working[EXEC_HI:EXEC_LO];
  assign driver_strength = working[DRV_HI:DRV_LO];
  assign hold_function_en = working[HOLD_EN_BIT];
  assign hold_active = hold_function_en && !hold_s && !cs_n_s;
  assign start_protocol = !working[QUAD_N_BIT] ? proto_quad :
                          !working[DUAL_N_BIT] ? proto_dual : proto_extended;
  assign ready = (por_state == st_ready);
  assign reads_only = (por_state == st_reads_only) && fast_por;
  assign polls_only = (por_state == st_second_phase);

  ////////////////////////////////////////////////////////////////////////////
  // Serial instruction engine, single line, mode 0.

  logic [7:0] cmd;
  logic [5:0] bit_cnt;
  logic [15:0] read_shift;
  logic reading;
  logic writing;
  wire cmd_complete = rise && (bit_cnt == 6'd7);
  wire [7:0] cmd_now = {cmd[6:0], din_s};
  wire accept_any = (por_state == st_ready);
  wire accept_read = accept_any || (por_state == st_reads_only);
  wire accept_poll = accept_any || (por_state == st_second_phase);
  wire is_read = (cmd_now == CMD_READ) || (cmd_now == CMD_FAST_READ);
  wire is_poll = (cmd_now == CMD_READ_STATUS) || (cmd_now == CMD_READ_FLAGS);
  wire start_read_word = cmd_complete && accept_any && (cmd_now == CMD_READ_WORD);
  wire start_write_word = cmd_complete && accept_any && (cmd_now == CMD_WRITE_WORD);
  wire frame_ok = accept_any || (accept_read && is_read) || (accept_poll && is_poll);
  assign latch_cmd_seen = cmd_complete && (cmd_now == CMD_WRITE_LATCH) && (por_state == st_reads_only);
  assign write_word_done = writing && rise && (bit_cnt == 6'd23) && !hold_active;

  always_ff @(posedge sys_clk)
  begin
    if (rst || cs_n_s)
    begin
      cmd <= 8'h00;
      bit_cnt <= 6'd0;
      reading <= 1'b0;
      writing <= 1'b0;
      write_shift <= 16'h0000;
    end
    else if (rise && !hold_active && bit_cnt != 6'd63)
    begin
      if (bit_cnt < 6'd8)
        cmd <= cmd_now;
      if (writing)
        write_shift <= {write_shift[14:0], din_s};
      bit_cnt <= (cmd_complete && !frame_ok) ? 6'd63 : bit_cnt + 6'd1;
      if (start_read_word)
        reading <= 1'b1;
      if (start_write_word)
        writing <= 1'b1;
      if (write_word_done)
        writing <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      read_shift <= 16'h0000;
      serial_out <= 1'b0;
    end
    else if (start_read_word)
      read_shift <= stored_word;
    else if (reading && fall && !hold_active)
    begin
      serial_out <= read_shift[15];
      read_shift <= {read_shift[14:0], read_shift[15]};
    end
  end

  assign serial_out_en = reading && !cs_n_s && !hold_active;
endmodule : nv_config_loader

// [tb/nv_config_loader_chk.sv]
/* Concurrent checks on the ports of the power-on configuration loader.
   Assumes the package power-on timings and a 20 MHz sys_clk. */
`timescale 1ns/1ps
module nv_config_loader_chk (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic power_on,
  input wire logic chip_select_n,
  input wire logic fourth_io_line,
  input wire logic serial_out_en,
  input wire logic [3:0] dummy_clocks,
  input wire logic [2:0] direct_execution_mode,
  input wire logic [2:0] driver_strength,
  input wire nv_config_pkg::protocol_e start_protocol,
  input wire logic hold_function_en,
  input wire logic hold_active,
  input wire logic ready,
  input wire logic reads_only,
  input wire logic polls_only
);
  import nv_config_pkg::*;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  logic [15:0] on_cnt;
  logic [15:0] poll_cnt;
  // Counters measure the power-on phases, which are far too long for a repetition.
  always_ff @(posedge sys_clk)
  begin
    if (rst || !power_on)
    begin
      on_cnt <= 16'h0;
      poll_cnt <= 16'h0;
    end
    else
    begin
      if (on_cnt != 16'hffff) on_cnt <= on_cnt + 16'h1;
      if (polls_only) poll_cnt <= poll_cnt + 16'h1;
    end
  end
  ////////////////////////////////////////
  chk_dummy_nonzero: assert property (dummy_clocks != 4'h0) else $error("dummy count zero");
  chk_config_held: assert property (ready |=> $stable({dummy_clocks, direct_execution_mode,
    driver_strength, start_protocol, hold_function_en})) else $error("config changed while ready");
  chk_one_phase: assert property ($onehot0({ready, reads_only, polls_only})) else $error("phases overlap");
  chk_fast_window: assert property ($rose(reads_only) |->
    on_cnt >= 16'h07c6 && on_cnt <= 16'h07cf) else $error("fast phase length");
  chk_ready_window: assert property ($rose(ready) |-> (on_cnt >= 16'h36ab && on_cnt <= 16'h36ba) ||
    (poll_cnt >= 16'h2706 && poll_cnt <= 16'h271a)) else $error("ready timing");
  chk_polls_end: assert property ($fell(polls_only) && power_on |-> ##[0:1] ready) else $error("no ready");
  chk_power_off: assert property ((!power_on)[*4] |-> !ready && !reads_only && !polls_only)
    else $error("active without power");
  chk_hold_follow: assert property ((hold_function_en && !fourth_io_line && !chip_select_n)[*4]
    |-> hold_active) else $error("hold missed");
  chk_out_quiet: assert property (chip_select_n[*4] |-> !serial_out_en) else $error("drives unselected");
  chk_delivery_config: assert property ($fell(rst) |-> dummy_clocks == 4'hf && direct_execution_mode == 3'h7 &&
    driver_strength == 3'h7 && hold_function_en && start_protocol == proto_extended) else $error("delivery config");
endmodule : nv_config_loader_chk
bind nv_config_loader nv_config_loader_chk u_chk (.sys_clk, .rst, .power_on, .chip_select_n, .fourth_io_line,
  .serial_out_en, .dummy_clocks, .direct_execution_mode, .driver_strength, .start_protocol, .hold_function_en,
  .hold_active, .ready, .reads_only, .polls_only);

// [tb/spi_host_model.sv]
/* Serial host: one instruction frame per chip-select, clock still between frames.
   Assumes a 400 ns link period; the device samples on rising edges. */
`timescale 1ns/1ps
module spi_host_model (
  output logic serial_clk,
  output logic chip_select_n,
  output logic serial_in,
  input wire logic serial_out
);
  initial
  begin
    serial_clk = 1'b0;
    chip_select_n = 1'b1;
    serial_in = 1'b0;
  end
  // Command then word, msb first; no fast reads are issued, so no dummy count is chosen.
  task automatic frame(input logic [23:0] bits_out, output logic [15:0] bits_in);
    bits_in = 16'h0;
    #7 chip_select_n = 1'b0;
    for (int i = 23; i >= 0; i--)
    begin
      serial_in = bits_out[i];
      #200 serial_clk = 1'b1;
      #200;
      if (i < 16) bits_in[i] = serial_out;
      serial_clk = 1'b0;
    end
    #200 chip_select_n = 1'b1;
    // The line has no pull, so a released line shows the inverse of its last value.
    serial_in = ~serial_in;
    #400;
  endtask : frame
endmodule : spi_host_model

// [tb/nv_config_loader_tb.sv]
/* Self-checking bench for the power-on configuration loader.
   Assumes the package timings: a full power-on takes some 14000 cycles. */
`timescale 1ns/1ps
module nv_config_loader_tb;
  import nv_config_pkg::*;
  logic sys_clk, rst, power_on, fourth_io_line, serial_clk, chip_select_n, serial_in, serial_out;
  logic serial_out_en, hold_function_en, hold_active, ready, reads_only, polls_only;
  logic [3:0] dummy_clocks;
  logic [2:0] direct_execution_mode, driver_strength;
  protocol_e start_protocol;
  logic [15:0] rd;
  int err_count = 0;
  int n_compared = 0;
  nv_config_loader u_nv_config_loader (.sys_clk, .rst, .power_on, .serial_clk, .chip_select_n, .serial_in,
    .serial_out, .serial_out_en, .fourth_io_line, .dummy_clocks, .direct_execution_mode, .driver_strength,
    .start_protocol, .hold_function_en, .hold_active, .ready, .reads_only, .polls_only);
  spi_host_model host (.serial_clk, .chip_select_n, .serial_in, .serial_out);
  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check
  function automatic logic [15:0] cfg_of(input logic [15:0] w);
    logic [1:0] p;
    p = !w[3] ? 2'(proto_quad) : (!w[2] ? 2'(proto_dual) : 2'(proto_extended));
    return {(w[15:12] == 4'h0) ? 4'hf : w[15:12], w[11:9], w[8:6], w[4], p, 3'h0};
  endfunction : cfg_of
  function automatic logic [15:0] cfg_now();
    return {dummy_clocks, direct_execution_mode, driver_strength, hold_function_en, 2'(start_protocol), 3'h0};
  endfunction : cfg_now
  task automatic wait_on(input logic [2:0] phase);
    for (int n = 0; n < 15000 && !(ready || reads_only); n++) @(negedge sys_clk);
    check({13'h0, ready, reads_only, polls_only}, {13'h0, phase}, "phase");
  endtask : wait_on
  task automatic power_up(input logic [2:0] phase);
    @(negedge sys_clk) power_on = 1'b0;
    repeat (4) @(negedge sys_clk);
    power_on = 1'b1;
    wait_on(phase);
  endtask : power_up
  ////////////////////////////////////////
  task automatic default_start;
    power_up(3'h4);
    check(cfg_now(), cfg_of(WORD_DELIVERY), "delivery config");
    @(negedge sys_clk) fourth_io_line = 1'b0;
    host.frame({CMD_WRITE_WORD, 16'h1234}, rd);
    @(negedge sys_clk) fourth_io_line = 1'b1;
    host.frame({CMD_READ_WORD, 16'h0}, rd);
    check(rd, 16'hffff, "write under hold");
  endtask : default_start
  task automatic fast_quad_start;
    host.frame({CMD_WRITE_WORD, 16'h44c0}, rd);
    host.frame({CMD_READ_WORD, 16'h0}, rd);
    check(rd, 16'h44c3, "stored word");
    check(cfg_now(), cfg_of(WORD_DELIVERY), "config before power cycle");
    power_up(3'h2);
    check(cfg_now(), cfg_of(16'h44c0), "quad config");
    host.frame({CMD_WRITE_WORD, 16'h0000}, rd);
    host.frame({CMD_WRITE_LATCH, 16'h0}, rd);
    host.frame({CMD_WRITE_WORD, 16'h0000}, rd);
    wait_on(3'h4);
    host.frame({CMD_READ_WORD, 16'h0}, rd);
    check(rd, 16'h44c3, "write refused while booting");
  endtask : fast_quad_start
  task automatic dual_start;
    @(negedge sys_clk) fourth_io_line = 1'b0;
    host.frame({CMD_WRITE_WORD, 16'h0ffb}, rd);
    @(negedge sys_clk) fourth_io_line = 1'b1;
    power_up(3'h4);
    check(cfg_now(), cfg_of(16'h0ffb), "dual config");
  endtask : dual_start
  task automatic finish_test;
    if (err_count == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test
  initial
  begin
    rst = 1'b1;
    power_on = 1'b0;
    fourth_io_line = 1'b1;
    repeat (16) @(negedge sys_clk);
    rst = 1'b0;
    default_start();
    fast_quad_start();
    dual_start();
    finish_test();
  end
  initial
  begin
    #3_000_000;
    err_count++;
    finish_test();
  end
endmodule : nv_config_loader_tb
